// [include/cbo_pkg.sv]
package cbo_pkg;
   localparam logic [9:0] IDX_CMD = 10'h000;
   localparam logic [9:0] IDX_CYC = 10'h002;
   localparam logic [9:0] IDX_OFS_TRK = 10'h004;
   localparam logic [9:0] IDX_POFS = 10'h006;
   localparam logic [9:0] IDX_TM01 = 10'h008;
   localparam logic [9:0] IDX_TM23 = 10'h00a;
   localparam logic [9:0] IDX_TM45 = 10'h00c;
   localparam logic [9:0] IDX_TM67 = 10'h00e;
   localparam logic [9:0] IDX_AVG = 10'h010;
   localparam logic [9:0] IDX_RSVD = 10'h012;
   localparam logic [9:0] IDX_MODULO = 10'h014;
   localparam logic [9:0] IDX_SRC_SEL = 10'h016;
   localparam logic [9:0] IDX_STATUS = 10'h018;
   localparam logic [9:0] IDX_POS = 10'h019;
   localparam logic [9:0] IDX_FLAG_BASE = 10'h040;
   localparam logic [9:0] IDX_TBL_BASE = 10'h080;
   localparam int FLAG_WORDS = 32;
   localparam int IMG_WORDS = 8;
   localparam int FUNC_COUNT = 8;
   localparam int MAX_TRACKS = 8;
   localparam int CMD_FCT_LSB = 8;
   localparam int CMD_CODE_LSB = 16;
   localparam int CMD_MODE_LSB = 24;
   localparam int HI_LSB = 16;
   localparam int SRC_OFS_LSB = 8;
   localparam int TM_OUT_INV = 0;
   localparam int TM_IN_INV = 1;
   localparam int TM_OP_LSB = 2;
   localparam int TM_FREEZE = 5;
   localparam int TM_WIDTH = 6;
   localparam logic [1:0] OP_AND = 2'h1;
   localparam logic [1:0] OP_OR = 2'h2;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [7:0] CODE_START = 8'h01;
   localparam logic [7:0] CODE_VALUE_NEW = 8'h05;
   localparam logic [7:0] MODE_ABS = 8'h00;
   localparam logic [7:0] MODE_INC = 8'h01;
   localparam logic [7:0] MODE_TIME = 8'h02;
   localparam logic [7:0] FCT_DEAD = 8'h01;
   localparam logic [7:0] SRC_DRIVE = 8'h12;
   localparam logic [7:0] SRC_FLAG_W = 8'h80;
   localparam logic [7:0] SRC_FLAG_D = 8'h81;
   localparam logic [7:0] SRC_IMG_W = 8'h82;
   localparam logic [7:0] SRC_IMG_D = 8'h83;
   localparam logic [7:0] SRC_FUNC = 8'hff;
   localparam logic [7:0] DRV_OFS_FULL = 8'h15;
   localparam logic [7:0] DRV_OFS_LOW = 8'h05;
   localparam logic [7:0] FLAG_W_MAX = 8'h7e;
   localparam logic [7:0] FLAG_D_MAX = 8'h7c;
   localparam logic [7:0] IMG_W_MAX = 8'h1e;
   localparam logic [7:0] IMG_D_MAX = 8'h1c;
   localparam logic [7:0] FUNC_MAX = 8'h07;
   localparam logic [31:0] MODULO_RESET = 32'h7fff_ffff;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CYCLE_UNIT_NS = 500000;
   localparam int unsigned UNIT_CLKS = (CYCLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } cbo_run_t;

   typedef struct packed {
      logic [7:0] mode;
      logic dead_en;
      logic [15:0] dead_time;
      logic [30:0] modulo;
      logic [15:0] incr;
   } cbo_acc_ctl_t;

   typedef struct packed {
      logic [31:0] pos;
      logic [31:0] lead;
      logic [15:0] prev;
      logic primed;
   } cbo_acc_st_t;

   typedef struct packed {
      logic out;
   } cbo_trk_st_t;
endpackage : cbo_pkg

// [verilog/cbo_pos_accum.sv]
`timescale 1ns/1ns
module cbo_pos_accum (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic step,
   input wire cbo_pkg::cbo_acc_ctl_t ctl,
   input wire logic [31:0] src,
   output logic [31:0] pos,
   output logic [31:0] pos_lead
);
   import cbo_pkg::*;
   cbo_acc_st_t r;
   cbo_acc_st_t n;
   logic [15:0] diff;
   logic [33:0] inc;
   logic [33:0] sum;
   logic [33:0] lim;
   logic signed [32:0] prod;

   always_comb begin
      n = r;
      diff = r.primed ? src[15:0] - r.prev : 16'h0000;
      inc = (ctl.mode == MODE_TIME) ? {18'h0_0000, ctl.incr} : {{18{diff[15]}}, diff};
      sum = {2'b00, r.pos} + inc;
      lim = {3'b000, ctl.modulo};
      prod = $signed(diff) * $signed({1'b0, ctl.dead_time});
      if (clear) begin
         n.pos = 32'h0000_0000;
         n.lead = 32'h0000_0000;
         n.primed = 1'b0;
      end else if (step) begin
         n.prev = src[15:0];
         n.primed = 1'b1;
         if (ctl.mode == MODE_ABS) begin
            n.pos = src;
         end else if (sum[33]) begin
            n.pos = sum[31:0] + lim[31:0] + 32'h0000_0001;
         end else if (sum > lim) begin
            n.pos = sum[31:0] - lim[31:0] - 32'h0000_0001;
         end else begin
            n.pos = sum[31:0];
         end
         // Lead is position plus velocity times dead time, no averaging and no second wrap
         n.lead = ctl.dead_en ? n.pos + prod[31:0] : n.pos;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign pos = r.pos;
   assign pos_lead = r.lead;
endmodule : cbo_pos_accum

// [verilog/cbo_track.sv]
`timescale 1ns/1ns
module cbo_track (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic update,
   input wire logic active,
   input wire logic table_bit,
   input wire logic in_bit,
   input wire logic [5:0] mode,
   output logic out
);
   import cbo_pkg::*;
   cbo_trk_st_t r;
   cbo_trk_st_t n;
   logic in_v;
   logic comb;

   always_comb begin
      n = r;
      in_v = in_bit ^ mode[TM_IN_INV];
      unique case (mode[TM_OP_LSB +: 2])
         OP_AND: comb = table_bit & in_v;
         OP_OR: comb = table_bit | in_v;
         // Code 3 is undefined; it behaves as no combination
         default: comb = table_bit;
      endcase
      if (clear) begin
         n.out = 1'b0;
      end else if (update && !mode[TM_FREEZE]) begin
         n.out = active & (comb ^ mode[TM_OUT_INV]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign out = r.out;
endmodule : cbo_track

// [verilog/cbo_cam_outputs.sv]
`timescale 1ns/1ns
module cbo_cam_outputs #(
   parameter int unsigned UNIT_CLKS = cbo_pkg::UNIT_CLKS,
   parameter int unsigned TBL_DEPTH = 64,
   parameter int unsigned TBL_SHIFT = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [cbo_pkg::MAX_TRACKS-1:0] bin_in,
   input wire logic [cbo_pkg::IMG_WORDS-1:0][31:0] input_image,
   input wire logic [cbo_pkg::FUNC_COUNT-1:0][31:0] func_out,
   input wire logic [31:0] drive_bus_channel,
   output logic [cbo_pkg::MAX_TRACKS-1:0] bin_out
);
   import cbo_pkg::*;

   localparam int IW = $clog2(TBL_DEPTH);
   localparam int UW = $clog2(UNIT_CLKS + 1);
   localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CLKS - 1);
   localparam logic [9:0] TBL_END = IDX_TBL_BASE + 10'(TBL_DEPTH);
   localparam logic [9:0] FLAG_END = IDX_FLAG_BASE + 10'(FLAG_WORDS);

   typedef struct packed {
      logic [31:0] cmd;
      logic [31:0] cyc;
      logic [31:0] ofs_trk;
      logic [31:0] pofs;
      logic [31:0] avg;
      logic [31:0] modulo;
      logic [31:0] src_sel;
      logic [3:0][31:0] tmode;
      logic [FLAG_WORDS-1:0][31:0] flag;
      logic [TBL_DEPTH-1:0][7:0] tbl;
      cbo_run_t st;
      logic [7:0] a_mode;
      logic [7:0] a_fct;
      logic [7:0] a_ofs_addr;
      logic [7:0] a_src_addr;
      logic [7:0] a_src_ofs;
      logic [3:0] a_tracks;
      logic [15:0] a_pofs;
      logic [15:0] a_dead;
      logic [15:0] a_cyc;
      logic [30:0] a_modulo;
      logic [3:0][31:0] a_tmode;
      logic [UW-1:0] unit_cnt;
      logic [15:0] cyc_cnt;
      logic tick;
      logic upd;
      logic clr;
      logic bad;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] filt;
      logic [31:0] rdata;
   } cbo_main_st_t;

   cbo_main_st_t r;
   cbo_main_st_t n;

   logic [9:0] idx;
   logic mapped;
   logic wr;
   logic [31:0] rd_word;
   logic [31:0] wv;
   logic [7:0] code;
   logic [32:0] src_pick;
   logic [31:0] ofs_val;
   logic [31:0] src_in;
   logic src_ok;
   logic [15:0] cyc_last;
   logic [31:0] pos;
   logic [31:0] pos_lead;
   logic [7:0] tbl_row;
   cbo_acc_ctl_t acc_ctl;

   function automatic logic is_flag(input logic [9:0] i);
      return (i >= IDX_FLAG_BASE) && (i < FLAG_END);
   endfunction : is_flag

   function automatic logic is_tbl(input logic [9:0] i);
      return (i >= IDX_TBL_BASE) && (i < TBL_END);
   endfunction : is_tbl

   function automatic logic [31:0] half_sx(input logic [31:0] w, input logic hi);
      logic [15:0] h;
      h = hi ? w[HI_LSB +: 16] : w[15:0];
      return {{16{h[15]}}, h};
   endfunction : half_sx

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[8*b +: 8] = d[8*b +: 8];
         end
      end
      return m;
   endfunction : merge

   // Returns {valid, value}; an offset off its grid or range gives zero, invalid
   function automatic logic [32:0] pick_src(
      input logic [7:0] a,
      input logic [7:0] o,
      input logic [FLAG_WORDS-1:0][31:0] flg,
      input logic [IMG_WORDS-1:0][31:0] img,
      input logic [FUNC_COUNT-1:0][31:0] fo,
      input logic [31:0] drv
   );
      logic [32:0] res;
      res = {1'b0, 32'h0000_0000};
      unique case (a)
         SRC_FLAG_W: begin
            if (!o[0] && o <= FLAG_W_MAX) begin
               res = {1'b1, half_sx(flg[o[6:2]], o[1])};
            end
         end
         SRC_FLAG_D: begin
            if (o[1:0] == 2'b00 && o <= FLAG_D_MAX) begin
               res = {1'b1, flg[o[6:2]]};
            end
         end
         SRC_IMG_W: begin
            if (!o[0] && o <= IMG_W_MAX) begin
               res = {1'b1, half_sx(img[o[4:2]], o[1])};
            end
         end
         SRC_IMG_D: begin
            if (o[1:0] == 2'b00 && o <= IMG_D_MAX) begin
               res = {1'b1, img[o[4:2]]};
            end
         end
         SRC_FUNC: begin
            if (o <= FUNC_MAX) begin
               res = {1'b1, fo[o[2:0]]};
            end
         end
         SRC_DRIVE: begin
            if (o == DRV_OFS_FULL) begin
               res = {1'b1, drv};
            end else if (o == DRV_OFS_LOW) begin
               res = {1'b1, half_sx(drv, 1'b0)};
            end
         end
         default: res = {1'b0, 32'h0000_0000};
      endcase
      return res;
   endfunction : pick_src

   assign idx = paddr[11:2];
   assign wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = r.rdata;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      mapped = is_flag(idx) | is_tbl(idx);
      unique case (idx)
         IDX_CMD, IDX_CYC, IDX_OFS_TRK, IDX_POFS, IDX_TM01, IDX_TM23,
         IDX_TM45, IDX_TM67, IDX_AVG, IDX_RSVD, IDX_MODULO, IDX_SRC_SEL,
         IDX_STATUS, IDX_POS: mapped = 1'b1;
         default: ;
      endcase
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (is_flag(idx)) begin
         rd_word = r.flag[idx[4:0]];
      end else if (is_tbl(idx)) begin
         rd_word = {24'h00_0000, r.tbl[idx[IW-1:0]]};
      end else begin
         unique case (idx)
            IDX_CMD: rd_word = r.cmd;
            IDX_CYC: rd_word = r.cyc;
            IDX_OFS_TRK: rd_word = r.ofs_trk;
            IDX_POFS: rd_word = r.pofs;
            IDX_TM01: rd_word = r.tmode[0];
            IDX_TM23: rd_word = r.tmode[1];
            IDX_TM45: rd_word = r.tmode[2];
            IDX_TM67: rd_word = r.tmode[3];
            IDX_AVG: rd_word = r.avg;
            IDX_MODULO: rd_word = r.modulo;
            IDX_SRC_SEL: rd_word = r.src_sel;
            IDX_STATUS: rd_word = {8'h00, r.filt, bin_out, 6'h00, r.bad, r.st == ST_RUN};
            IDX_POS: rd_word = pos;
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   // Source and offset path, evaluated from the active copy of the setup
   always_comb begin
      src_pick = pick_src(r.a_src_addr, r.a_src_ofs, r.flag, input_image, func_out,
                          drive_bus_channel);
      if (r.a_ofs_addr == 8'h00) begin
         ofs_val = {{16{r.a_pofs[15]}}, r.a_pofs};
      end else begin
         ofs_val = half_sx(r.flag[r.a_ofs_addr[6:2]], r.a_ofs_addr[1]);
      end
      // Time mode reads no source, so a zero source selection is never flagged
      if (r.a_mode == MODE_TIME) begin
         src_in = 32'h0000_0000;
         src_ok = 1'b1;
      end else begin
         src_in = src_pick[31:0] + ofs_val;
         src_ok = src_pick[32];
      end
      cyc_last = (r.a_cyc == 16'h0000) ? 16'h0000 : r.a_cyc - 16'h0001;
      acc_ctl.mode = r.a_mode;
      acc_ctl.dead_en = (r.a_mode == MODE_INC) && (r.a_fct == FCT_DEAD);
      acc_ctl.dead_time = r.a_dead;
      acc_ctl.modulo = r.a_modulo;
      acc_ctl.incr = r.a_cyc;
      tbl_row = r.tbl[pos_lead[TBL_SHIFT +: IW]];
   end

   always_comb begin
      n = r;
      n.tick = 1'b0;
      n.clr = 1'b0;
      n.upd = r.tick;
      code = 8'h00;
      wv = merge(rd_word, pwdata, pstrb);
      n.s1 = bin_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.filt = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.filt);
      if (psel && !penable) begin
         n.rdata = rd_word;
      end
      if (r.st == ST_RUN) begin
         if (r.unit_cnt == UNIT_LAST) begin
            n.unit_cnt = '0;
            if (r.cyc_cnt >= cyc_last) begin
               n.cyc_cnt = 16'h0000;
               n.tick = 1'b1;
            end else begin
               n.cyc_cnt = r.cyc_cnt + 16'h0001;
            end
         end else begin
            n.unit_cnt = r.unit_cnt + UW'(1);
         end
      end
      if (wr && mapped) begin
         if (is_flag(idx)) begin
            n.flag[idx[4:0]] = wv;
         end else if (is_tbl(idx)) begin
            n.tbl[idx[IW-1:0]] = wv[7:0];
         end else begin
            unique case (idx)
               IDX_CMD: n.cmd = wv;
               IDX_CYC: n.cyc = wv;
               IDX_OFS_TRK: n.ofs_trk = wv;
               IDX_POFS: n.pofs = wv;
               IDX_TM01: n.tmode[0] = wv;
               IDX_TM23: n.tmode[1] = wv;
               IDX_TM45: n.tmode[2] = wv;
               IDX_TM67: n.tmode[3] = wv;
               IDX_AVG: n.avg = wv;
               IDX_MODULO: n.modulo = {1'b0, wv[30:0]};
               IDX_SRC_SEL: n.src_sel = wv;
               default: ;
            endcase
         end
         if (idx == IDX_CMD) begin
            code = wv[CMD_CODE_LSB +: 8];
            // Sink fields and basic drive modes have no register at all
            if (code == CODE_RESET) begin
               n.st = ST_IDLE;
               n.clr = 1'b1;
               // A tick already in flight must not refill the cleared tracks
               n.tick = 1'b0;
               n.upd = 1'b0;
            end else if (code == CODE_START) begin
               n.st = ST_RUN;
               n.clr = 1'b1;
               n.tick = 1'b0;
               n.upd = 1'b0;
               n.bad = 1'b0;
               n.unit_cnt = '0;
               n.cyc_cnt = 16'h0000;
               n.a_mode = wv[CMD_MODE_LSB +: 8];
               n.a_fct = wv[CMD_FCT_LSB +: 8];
               n.a_dead = r.cyc[15:0];
               n.a_cyc = r.cyc[HI_LSB +: 16];
               n.a_tracks = r.ofs_trk[3:0];
               n.a_ofs_addr = r.ofs_trk[HI_LSB +: 8];
               n.a_pofs = r.pofs[15:0];
               n.a_modulo = r.modulo[30:0];
               n.a_src_addr = r.src_sel[7:0];
               n.a_src_ofs = r.src_sel[SRC_OFS_LSB +: 8];
               n.a_tmode = r.tmode;
            end else if (code == CODE_VALUE_NEW && r.st == ST_RUN) begin
               n.a_pofs = r.pofs[15:0];
               if (r.a_mode == MODE_INC && r.a_fct == FCT_DEAD) begin
                  n.a_dead = r.cyc[15:0];
               end
            end
         end
      end
      // A bad source seen in the start cycle still sets the flag
      if (r.tick && !src_ok) begin
         n.bad = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.modulo <= MODULO_RESET;
      end else begin
         r <= n;
      end
   end

   cbo_pos_accum u_accum (
      .pclk(pclk),
      .presetn(presetn),
      .clear(r.clr),
      .step(r.tick),
      .ctl(acc_ctl),
      .src(src_in),
      .pos(pos),
      .pos_lead(pos_lead)
   );

   genvar k;
   generate
      for (k = 0; k < MAX_TRACKS; k++) begin : g_trk
         cbo_track u_trk (
            .pclk(pclk),
            .presetn(presetn),
            .clear(r.clr),
            .update(r.upd),
            .active(4'(k) < r.a_tracks),
            .table_bit(tbl_row[k]),
            .in_bit(r.filt[k]),
            .mode(r.a_tmode[k / 2][(k % 2) * 16 +: TM_WIDTH]),
            .out(bin_out[k])
         );
      end
   endgenerate
endmodule : cbo_cam_outputs

// [dv/cbo_cam_outputs_monitor.sv]
`timescale 1ns/1ns
module cbo_cam_outputs_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] bin_out
);
   logic acc, cmd_wr, rd_st, run, md0;
   assign acc = psel && penable;
   assign cmd_wr = acc && pwrite && paddr[11:2] == 10'h000;
   assign rd_st = acc && !pwrite && paddr == 12'h060;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 1'b0;
         md0 <= 1'b1;
      end else if (cmd_wr && pwdata[23:16] == 8'h01) begin
         run <= 1'b1;
         md0 <= pwdata[31:24] == 8'h00;
      end else if (cmd_wr && pwdata[23:16] == 8'h00) begin
         run <= 1'b0;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (acc |-> pready) else $error("no ready");
   a_err_access: assert property (pslverr |-> acc) else $error("stray error");
   a_unmapped_err: assert property (acc && paddr == 12'h300 |-> pslverr && prdata == 0)
      else $error("unmapped not refused");
   a_reserved_zero: assert property (acc && !pwrite && paddr == 12'h048 |-> !pslverr
      && prdata == 0) else $error("reserved word not zero");
   a_reset_clear: assert property ($rose(presetn) |-> bin_out == 8'h00)
      else $error("outputs not cleared");
   a_cmd_clear: assert property (cmd_wr && pwdata[23:16] == 8'h00 |=> ##1 bin_out == 8'h00)
      else $error("reset command kept outputs");
   a_run_status: assert property (rd_st |-> prdata[0] == run) else $error("run bit");
   a_sign_clear: assert property (acc && !pwrite && (paddr == 12'h050
      || (paddr == 12'h064 && !md0)) |-> !prdata[31]) else $error("sign bit set");
   a_status_mirror: assert property (rd_st |-> prdata[15:8] == $past(bin_out))
      else $error("status outputs differ");
   a_out_rate: assert property ($changed(bin_out) |=> $stable(bin_out) [*3])
      else $error("outputs changed within a cycle");
endmodule : cbo_cam_outputs_monitor
bind cbo_cam_outputs cbo_cam_outputs_monitor i_cbo_cam_outputs_monitor (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bin_out(bin_out));

// [dv/cbo_ctrl_model.sv]
`timescale 1ns/1ns
module cbo_ctrl_model (
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   output logic [7:0][31:0] input_image,
   output logic [7:0][31:0] func_out,
   output logic [31:0] drive_bus_channel
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      input_image = '0;
      func_out = '0;
      input_image[3] = 32'h0222_0111;
      func_out[6] = 32'h0000_7000;
      drive_bus_channel = 32'h1234_5678;
   end
   // Any byte strobe pattern the caller gives; callers also write all ones to the reserved word
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask : xfer
   task automatic set_drive(input logic [31:0] d);
      @(posedge pclk);
      drive_bus_channel <= d;
   endtask : set_drive
endmodule : cbo_ctrl_model

// [dv/cbo_cam_outputs_tb.sv]
`timescale 1ns/1ns
module cbo_cam_outputs_tb;
   import cbo_pkg::*;
   localparam logic [7:0][5:0] TMODE = {6'h00, 6'h03, 6'h20, 6'h06, 6'h08, 6'h04, 6'h01, 6'h00};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, drv, q;
   logic [3:0] pstrb;
   logic [7:0] bin_in, bin_out;
   logic [7:0][31:0] img, fo;
   int err_count, tests_run;
   cbo_cam_outputs #(.UNIT_CLKS(4), .TBL_DEPTH(16), .TBL_SHIFT(0)) i_cbo_cam_outputs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bin_in(bin_in), .input_image(img), .func_out(fo),
      .drive_bus_channel(drv), .bin_out(bin_out));
   cbo_ctrl_model i_cbo_ctrl_model (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .input_image(img), .func_out(fo),
      .drive_bus_channel(drv));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_cbo_ctrl_model.xfer(1'b1, a, d, 4'hf, q, e);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      i_cbo_ctrl_model.xfer(1'b0, a, 32'h0000_0000, 4'h0, q, e);
   endtask : rd
   // Reset command first so every run starts from a cleared accumulator
   task automatic go(input logic [31:0] cmd, input int n);
      wr(12'h000, 32'h0000_0000);
      wr(12'h000, cmd);
      repeat (n) @(posedge pclk);
   endtask : go
   // Modulo is 9 for every caller, so the wrap span is 10
   task automatic trace(input int st, input int inc, input int n, input int mc);
      int s;
      int ch;
      logic [31:0] last;
      ch = 0;
      last = 32'(st);
      repeat (n) begin
         rd(12'h064);
         if (q !== last) begin
            s = int'(last) + inc;
            s = s < 0 ? s + 10 : s > 9 ? s - 10 : s;
            chk("position", 32'(s), q);
            last = q;
            ch++;
         end
      end
      chk("steps", 32'h0000_0001, {31'h0, ch >= mc});
   endtask : trace
   task automatic t_regs();
      rd(12'h050);
      chk("modulo", 32'h7fff_ffff, q);
      wr(12'h100, 32'h1111_1111);
      i_cbo_ctrl_model.xfer(1'b1, 12'h100, 32'h2222_2222, 4'h4, q, e);
      rd(12'h100);
      chk("byte strobe", 32'h1122_1111, q);
      wr(12'h048, 32'hffff_ffff);
      rd(12'h048);
      chk("reserved", 32'h0000_0000, q);
      rd(12'h300);
      chk("unmapped", 32'h0000_0001, {31'h0, e});
      $display("regs done");
   endtask : t_regs
   task automatic t_abs();
      logic [31:0] sel[3] = '{32'h0000_1512, 32'h0000_0c83, 32'h0000_06ff};
      logic [31:0] ex[3] = '{32'h1234_5688, 32'h0222_0121, 32'h0000_7010};
      wr(12'h008, 32'h0001_0000);
      wr(12'h018, 32'h0000_0010);
      for (int i = 0; i < 3; i++) begin
         wr(12'h058, sel[i]);
         go(32'h0001_0000, 12);
         rd(12'h064);
         chk("abs position", ex[i], q);
      end
      rd(12'h060);
      chk("running", 32'h0000_0001, {31'h0, q[0]});
      wr(12'h018, 32'h0000_fff0);
      repeat (12) @(posedge pclk);
      rd(12'h064);
      chk("offset held", 32'h0000_7010, q);
      wr(12'h000, 32'h0005_0000);
      repeat (12) @(posedge pclk);
      rd(12'h064);
      chk("value new", 32'h0000_6ff0, q);
      $display("abs done");
   endtask : t_abs
   task automatic t_time();
      wr(12'h050, 32'h0000_0009);
      wr(12'h058, 32'h0000_0000);
      wr(12'h008, 32'h0004_0000);
      go(32'h0201_0000, 0);
      trace(0, 4, 40, 5);
      $display("time done");
   endtask : t_time
   task automatic t_inc();
      wr(12'h058, 32'h0000_0512);
      wr(12'h008, 32'h0001_0000);
      wr(12'h018, 32'h0000_0000);
      i_cbo_ctrl_model.set_drive(32'h0000_7ffe);
      go(32'h0101_0000, 12);
      i_cbo_ctrl_model.set_drive(32'h0000_8001);
      trace(0, 3, 8, 1);
      i_cbo_ctrl_model.set_drive(32'h0000_7ffb);
      trace(3, -6, 8, 1);
      $display("inc done");
   endtask : t_inc
   task automatic t_bad();
      wr(12'h058, 32'h0000_0180);
      go(32'h0001_0000, 12);
      rd(12'h060);
      chk("bad source", 32'h0000_0001, {31'h0, q[1]});
      $display("bad done");
   endtask : t_bad
   task automatic t_trk();
      logic [7:0] b, x;
      logic inp, c, t;
      wr(12'h058, 32'h0000_0080);
      wr(12'h100, 32'h0000_0003);
      wr(12'h20c, 32'h0000_005a);
      wr(12'h010, 32'h0000_0007);
      wr(12'h020, 32'h0001_0000);
      wr(12'h028, 32'h0008_0004);
      wr(12'h030, 32'h0020_0006);
      wr(12'h038, 32'h0000_0003);
      go(32'h0001_0000, 0);
      for (int j = 0; j < 3; j++) begin
         b = j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'h0f;
         bin_in <= b;
         repeat (30) @(posedge pclk);
         for (int k = 0; k < 8; k++) begin
            t = 1'(8'h5a >> k);
            inp = b[k] ^ TMODE[k][1];
            c = TMODE[k][3:2] == 2'h1 ? t & inp : TMODE[k][3:2] == 2'h2 ? t | inp : t;
            x[k] = k < 7 && !TMODE[k][5] && (c ^ TMODE[k][0]);
         end
         chk("tracks", {24'h0, x}, {24'h0, bin_out});
      end
      // Reset command while outputs are set must clear them and stop the ticks
      wr(12'h000, 32'h0000_0000);
      repeat (12) @(posedge pclk);
      chk("tracks cleared", 32'h0000_0000, {24'h0, bin_out});
      $display("tracks done");
   endtask : t_trk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      err_count = 0;
      tests_run = 0;
      presetn = 1'b0;
      bin_in = 8'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_abs();
      t_time();
      t_inc();
      t_bad();
      t_trk();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      $display("[ERR] watchdog expected done seen hang");
      wrap_up();
   end
endmodule : cbo_cam_outputs_tb
